/* core/cam_defs.svh */
// Offsets, field positions, reset values and sizes of the counter array mode control
`ifndef CAM_DEFS_SVH
`define CAM_DEFS_SVH

`define CAM_NUM_MODULES 6
`define CAM_ADDR_MODE0 8'hda
`define CAM_ADDR_MODE1 8'hdb
`define CAM_ADDR_MODE2 8'hdc
`define CAM_ADDR_MODE3 8'hdd
`define CAM_ADDR_MODE4 8'hde
`define CAM_ADDR_MODE5 8'hce
`define CAM_ADDR_CNT_LO 8'hf9
`define CAM_ADDR_CNT_HI 8'hfa
`define CAM_ADDR_CPL0 8'hfb
`define CAM_ADDR_CPL1 8'he9
`define CAM_ADDR_CPL2 8'heb
`define CAM_ADDR_CPL3 8'hed
`define CAM_ADDR_CPL4 8'hfd
`define CAM_ADDR_CPL5 8'hd2
`define CAM_ADDR_CPH0 8'hfc
`define CAM_ADDR_CPH1 8'hea
`define CAM_ADDR_CPH2 8'hec
`define CAM_ADDR_CPH3 8'hee
`define CAM_ADDR_CPH4 8'hfe
`define CAM_ADDR_CPH5 8'hd3
`define CAM_BIT_WIDE_PULSE 7
`define CAM_BIT_COMPARE 6
`define CAM_BIT_RISE_CAP 5
`define CAM_BIT_FALL_CAP 4
`define CAM_BIT_MATCH_FLAG 3
`define CAM_BIT_FLIP 2
`define CAM_BIT_PULSE_MOD 1
`define CAM_BIT_FLAG_IRQ 0
`define CAM_MODE_RESET 8'h00
`define CAM_BYTE_RESET 8'h00
`define CAM_WDOG_MODULE 3'h5
`define CAM_NO_INDEX 3'h7

`endif

/* core/cam_pkg.sv */
// Types shared by the counter array mode control files
package cam_pkg;

   // Field order follows the mode register from bit 7 down to bit 0
   typedef struct packed {
      logic wide_pulse_select;
      logic compare_enable;
      logic rise_capture_enable;
      logic fall_capture_enable;
      logic match_flag_enable;
      logic output_flip_enable;
      logic pulse_mod_enable;
      logic flag_irq_enable;
   } cam_mode_type;

   typedef enum {
      CAM_FN_IDLE,
      CAM_FN_TOGGLE,
      CAM_FN_PWM8,
      CAM_FN_PWM16,
      CAM_FN_FREQ
   } cam_function_type;

   typedef struct packed {
      logic match;
      logic capture;
      logic flag_set;
   } cam_event_type;

endpackage : cam_pkg

/* core/cam_sync.sv */
// Two-flop synchroniser for the capture input pins
`timescale 1ns/1ps

module cam_sync #(
   parameter int WIDTH = 6
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule : cam_sync

/* core/cam_channel.sv */
// One capture/compare module: edge capture, match, toggle, PWM and frequency output
`timescale 1ns/1ps
`include "cam_defs.svh"

module cam_channel (
   input wire logic mclk,
   input wire logic nrst,
   input cam_pkg::cam_mode_type mode,
   input wire logic [15:0] count,
   input wire logic [15:0] capcmp,
   input wire logic cap_level,
   output cam_pkg::cam_event_type evt,
   output logic pin_r
);

   cam_pkg::cam_function_type fn;
   logic cap_prev_r;
   logic rise;
   logic fall;
   logic full_eq;
   logic low_eq;
   logic pwm_level;

   // Toggle together with PWM means frequency output, which outranks both
   always_comb begin
      if (mode.output_flip_enable && mode.pulse_mod_enable) begin
         fn = cam_pkg::CAM_FN_FREQ;
      end else if (mode.pulse_mod_enable) begin
         fn = mode.wide_pulse_select ? cam_pkg::CAM_FN_PWM16 : cam_pkg::CAM_FN_PWM8;
      end else if (mode.output_flip_enable) begin
         fn = cam_pkg::CAM_FN_TOGGLE;
      end else begin
         fn = cam_pkg::CAM_FN_IDLE;
      end
   end

   assign rise = cap_level && !cap_prev_r;
   assign fall = !cap_level && cap_prev_r;
   assign full_eq = mode.compare_enable && (count == capcmp);
   assign low_eq = mode.compare_enable && (count[7:0] == capcmp[7:0]);

   always_comb begin
      evt.capture = (rise && mode.rise_capture_enable)
         || (fall && mode.fall_capture_enable);
      evt.match = (fn == cam_pkg::CAM_FN_FREQ) ? low_eq : full_eq;
      evt.flag_set = evt.capture || (evt.match && mode.match_flag_enable);
   end

   // Duty follows the high byte in 8-bit PWM so a low-byte write does not glitch it
   always_comb begin
      if (fn == cam_pkg::CAM_FN_PWM16) begin
         pwm_level = mode.compare_enable && (count < capcmp);
      end else begin
         pwm_level = mode.compare_enable && (count[7:0] < capcmp[15:8]);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cap_prev_r <= 1'b0;
      end else begin
         cap_prev_r <= cap_level;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pin_r <= 1'b0;
      end else begin
         case (fn)
            cam_pkg::CAM_FN_TOGGLE, cam_pkg::CAM_FN_FREQ: begin
               if (evt.match) begin
                  pin_r <= !pin_r;
               end
            end
            cam_pkg::CAM_FN_PWM8, cam_pkg::CAM_FN_PWM16: begin
               pin_r <= pwm_level;
            end
            default: begin
               pin_r <= pin_r;
            end
         endcase
      end
   end

endmodule : cam_channel

/* core/cam_mode_ctrl.sv */
// Mode control, counter low byte and compare registers of the six-module counter array
//
// Behaviour
// - Wide select picks 16-bit or 8-bit PWM
// - Compare enable turns on the counter comparator
// - Rise capture enable arms positive-edge capture
// - Fall capture enable arms negative-edge capture
// - Match function sets the module event flag
// - Toggle function flips output pin on match
// - Toggle plus PWM gives frequency output
// - PWM enable drives modulated waveform on pin
// - Flag interrupt enable masks event flag request
// - Watchdog enable locks module five mode
// - Counter low byte reads/writes counter bits 7:0
// - Watchdog enable blocks counter low-byte writes
// - Low-byte read snapshots high byte for later
// - Compare low-byte write clears compare enable
`timescale 1ns/1ps
`include "cam_defs.svh"

module cam_mode_ctrl #(
   parameter int NMOD = `CAM_NUM_MODULES
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic count_tick,
   input wire logic wdog_enable_bit,
   input wire logic [NMOD-1:0] capture_pin,
   input wire logic [NMOD-1:0] flag_clear,
   output logic [NMOD-1:0] module_output_pin,
   output logic [NMOD-1:0] module_event_flag,
   output logic flag_irq,
   output logic wdog_expire
);

   // ************************************************************
   // Address decode
   // ************************************************************

   // Kind 0 picks mode registers, 1 compare low bytes, 2 compare high bytes
   function automatic logic [2:0] slot_of(input logic [7:0] addr, input logic [1:0] kind);
      logic [2:0] idx;
      idx = `CAM_NO_INDEX;
      case (kind)
         2'h0: begin
            case (addr)
               `CAM_ADDR_MODE0: idx = 3'h0;
               `CAM_ADDR_MODE1: idx = 3'h1;
               `CAM_ADDR_MODE2: idx = 3'h2;
               `CAM_ADDR_MODE3: idx = 3'h3;
               `CAM_ADDR_MODE4: idx = 3'h4;
               `CAM_ADDR_MODE5: idx = 3'h5;
               default: idx = `CAM_NO_INDEX;
            endcase
         end
         2'h1: begin
            case (addr)
               `CAM_ADDR_CPL0: idx = 3'h0;
               `CAM_ADDR_CPL1: idx = 3'h1;
               `CAM_ADDR_CPL2: idx = 3'h2;
               `CAM_ADDR_CPL3: idx = 3'h3;
               `CAM_ADDR_CPL4: idx = 3'h4;
               `CAM_ADDR_CPL5: idx = 3'h5;
               default: idx = `CAM_NO_INDEX;
            endcase
         end
         default: begin
            case (addr)
               `CAM_ADDR_CPH0: idx = 3'h0;
               `CAM_ADDR_CPH1: idx = 3'h1;
               `CAM_ADDR_CPH2: idx = 3'h2;
               `CAM_ADDR_CPH3: idx = 3'h3;
               `CAM_ADDR_CPH4: idx = 3'h4;
               `CAM_ADDR_CPH5: idx = 3'h5;
               default: idx = `CAM_NO_INDEX;
            endcase
         end
      endcase
      return idx;
   endfunction : slot_of

   logic [2:0] mode_slot;
   logic [2:0] cpl_slot;
   logic [2:0] cph_slot;
   logic cnt_lo_hit;
   logic cnt_hi_hit;

   assign mode_slot = slot_of(sfr_addr, 2'h0);
   assign cpl_slot = slot_of(sfr_addr, 2'h1);
   assign cph_slot = slot_of(sfr_addr, 2'h2);
   assign cnt_lo_hit = (sfr_addr == `CAM_ADDR_CNT_LO);
   assign cnt_hi_hit = (sfr_addr == `CAM_ADDR_CNT_HI);

   // ************************************************************
   // Shared counter and high-byte snapshot
   // ************************************************************

   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic [7:0] snap_r;

   always_comb begin
      cnt_nxt = count_tick ? cnt_r + 16'h0001 : cnt_r;
      // The watchdog owns the counter while enabled, so software cannot move it
      if (sfr_wr && !wdog_enable_bit && cnt_lo_hit) begin
         cnt_nxt[7:0] = sfr_wdata;
      end
      if (sfr_wr && !wdog_enable_bit && cnt_hi_hit) begin
         cnt_nxt[15:8] = sfr_wdata;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= {`CAM_BYTE_RESET, `CAM_BYTE_RESET};
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // A 16-bit read is coherent only if the low byte is read first
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         snap_r <= `CAM_BYTE_RESET;
      end else if (sfr_rd && cnt_lo_hit) begin
         snap_r <= cnt_r[15:8];
      end
   end

   // ************************************************************
   // Per-module registers and channels
   // ************************************************************

   cam_pkg::cam_mode_type mode_r [NMOD];
   logic [15:0] cc_r [NMOD];
   cam_pkg::cam_event_type evt [NMOD];
   logic [NMOD-1:0] cap_sync;

   cam_sync #(
      .WIDTH(NMOD)
   ) i_cam_sync (
      .mclk(mclk),
      .nrst(nrst),
      .async_in(capture_pin),
      .sync_out(cap_sync)
   );

   genvar gi;
   generate
      for (gi = 0; gi < NMOD; gi++) begin : g_mod
         logic mode_lock;
         logic mode_wr;
         logic cpl_wr;
         logic cph_wr;

         // The lock also covers the compare-enable clear of a low-byte write
         assign mode_lock = wdog_enable_bit && (3'(gi) == `CAM_WDOG_MODULE);
         assign mode_wr = sfr_wr && (mode_slot == 3'(gi)) && !mode_lock;
         assign cpl_wr = sfr_wr && (cpl_slot == 3'(gi));
         assign cph_wr = sfr_wr && (cph_slot == 3'(gi));

         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               mode_r[gi] <= `CAM_MODE_RESET;
            end else if (mode_wr) begin
               mode_r[gi] <= sfr_wdata;
            end else if (cpl_wr && !mode_lock) begin
               mode_r[gi].compare_enable <= 1'b0;
            end
         end

         // Software writes outrank a capture landing in the same cycle
         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               cc_r[gi] <= {`CAM_BYTE_RESET, `CAM_BYTE_RESET};
            end else if (cpl_wr || cph_wr) begin
               if (cpl_wr) begin
                  cc_r[gi][7:0] <= sfr_wdata;
               end
               if (cph_wr) begin
                  cc_r[gi][15:8] <= sfr_wdata;
               end
            end else if (evt[gi].capture) begin
               cc_r[gi] <= cnt_r;
            end
         end

         cam_channel i_cam_channel (
            .mclk(mclk),
            .nrst(nrst),
            .mode(mode_r[gi]),
            .count(cnt_r),
            .capcmp(cc_r[gi]),
            .cap_level(cap_sync[gi]),
            .evt(evt[gi]),
            .pin_r(module_output_pin[gi])
         );

         // A new event wins over a clear in the same cycle
         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               module_event_flag[gi] <= 1'b0;
            end else if (evt[gi].flag_set) begin
               module_event_flag[gi] <= 1'b1;
            end else if (flag_clear[gi]) begin
               module_event_flag[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ************************************************************
   // Interrupt request and watchdog match
   // ************************************************************

   logic [NMOD-1:0] irq_mask;
   always_comb begin
      for (int i = 0; i < NMOD; i++) begin
         irq_mask[i] = mode_r[i].flag_irq_enable;
      end
   end

   assign flag_irq = |(module_event_flag & irq_mask);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wdog_expire <= 1'b0;
      end else begin
         wdog_expire <= wdog_enable_bit
            && (cnt_r[15:8] == cc_r[`CAM_WDOG_MODULE][15:8]);
      end
   end

   // ************************************************************
   // Read data
   // ************************************************************

   logic [7:0] rdata_nxt;
   always_comb begin
      rdata_nxt = `CAM_BYTE_RESET;
      if (mode_slot != `CAM_NO_INDEX) begin
         rdata_nxt = mode_r[mode_slot];
      end else if (cpl_slot != `CAM_NO_INDEX) begin
         rdata_nxt = cc_r[cpl_slot][7:0];
      end else if (cph_slot != `CAM_NO_INDEX) begin
         rdata_nxt = cc_r[cph_slot][15:8];
      end else if (cnt_lo_hit) begin
         rdata_nxt = cnt_r[7:0];
      end else if (cnt_hi_hit) begin
         rdata_nxt = snap_r;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sfr_rdata <= `CAM_BYTE_RESET;
      end else if (sfr_rd) begin
         sfr_rdata <= rdata_nxt;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************

   property p_mode5_locked;
      @(posedge mclk) disable iff (!nrst)
      wdog_enable_bit |=> $stable(mode_r[5]);
   endproperty
   a_mode5_locked: assert property (p_mode5_locked) else $error("module 5 mode changed");

   property p_low_locked;
      @(posedge mclk) disable iff (!nrst)
      (sfr_wr && cnt_lo_hit && wdog_enable_bit && !count_tick)
         |=> (cnt_r[7:0] == $past(cnt_r[7:0]));
   endproperty
   a_low_locked: assert property (p_low_locked) else $error("low byte written under watchdog");

   property p_low_write;
      @(posedge mclk) disable iff (!nrst)
      (sfr_wr && cnt_lo_hit && !wdog_enable_bit) |=> (cnt_r[7:0] == $past(sfr_wdata));
   endproperty
   a_low_write: assert property (p_low_write) else $error("low byte write lost");

   property p_snapshot;
      @(posedge mclk) disable iff (!nrst)
      (sfr_rd && cnt_lo_hit) ##1 (sfr_rd && cnt_hi_hit && !(sfr_wr))
         |=> (sfr_rdata == $past(snap_r)) && ($past(snap_r) == $past(cnt_r[15:8], 2));
   endproperty
   a_snapshot: assert property (p_snapshot) else $error("high byte not from snapshot");

   property p_cpl_clears;
      @(posedge mclk) disable iff (!nrst)
      (sfr_wr && cpl_slot == 3'h0) |=> !mode_r[0].compare_enable;
   endproperty
   a_cpl_clears: assert property (p_cpl_clears) else $error("compare enable kept");

   property p_match_flag;
      @(posedge mclk) disable iff (!nrst)
      (mode_r[0].compare_enable && mode_r[0].match_flag_enable && !mode_r[0].pulse_mod_enable
         && cnt_r == cc_r[0]) |=> module_event_flag[0];
   endproperty
   a_match_flag: assert property (p_match_flag) else $error("match did not set flag");

   property p_toggle;
      @(posedge mclk) disable iff (!nrst)
      (mode_r[1].compare_enable && mode_r[1].output_flip_enable
         && !mode_r[1].pulse_mod_enable && cnt_r == cc_r[1])
         |=> module_output_pin[1] != $past(module_output_pin[1]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("output did not toggle");

   property p_irq_mask;
      @(posedge mclk) disable iff (!nrst)
      ((module_event_flag[0] && mode_r[0].flag_irq_enable) |-> flag_irq)
         and ((module_event_flag[0] && !mode_r[0].flag_irq_enable
         && !(|module_event_flag[NMOD-1:1])) |-> !flag_irq);
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("interrupt mask wrong");

   property p_capture;
      @(posedge mclk) disable iff (!nrst)
      (evt[4].capture && !(sfr_wr && (cpl_slot == 3'h4 || cph_slot == 3'h4)))
         |=> (cc_r[4] == $past(cnt_r)) && module_event_flag[4];
   endproperty
   a_capture: assert property (p_capture) else $error("capture missed");

endmodule : cam_mode_ctrl

/* testbench/cam_mode_ctrl_tb.sv */
// Self-checking testbench of the counter array mode control block
`timescale 1ns/1ps
`include "cam_defs.svh"

module cam_mode_ctrl_tb;
   // ****************************************
   // Signals and bookkeeping
   // ****************************************
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic count_tick = 1'b0;
   logic wdog_enable_bit = 1'b0;
   logic [5:0] capture_pin = 6'h00;
   logic [5:0] flag_clear = 6'h00;
   logic [5:0] module_output_pin;
   logic [5:0] module_event_flag;
   logic flag_irq;
   logic wdog_expire;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   logic [7:0] mode_a [6] = '{`CAM_ADDR_MODE0, `CAM_ADDR_MODE1, `CAM_ADDR_MODE2,
                              `CAM_ADDR_MODE3, `CAM_ADDR_MODE4, `CAM_ADDR_MODE5};
   logic [7:0] cpl_a [6] = '{`CAM_ADDR_CPL0, `CAM_ADDR_CPL1, `CAM_ADDR_CPL2,
                             `CAM_ADDR_CPL3, `CAM_ADDR_CPL4, `CAM_ADDR_CPL5};
   logic [7:0] cph_a [6] = '{`CAM_ADDR_CPH0, `CAM_ADDR_CPH1, `CAM_ADDR_CPH2,
                             `CAM_ADDR_CPH3, `CAM_ADDR_CPH4, `CAM_ADDR_CPH5};
   logic [7:0] rd_v;
   logic got;

   always #10 mclk = ~mclk;

   cam_mode_ctrl i_cam_mode_ctrl (
      .mclk(mclk),
      .nrst(nrst),
      .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata),
      .count_tick(count_tick),
      .wdog_enable_bit(wdog_enable_bit),
      .capture_pin(capture_pin),
      .flag_clear(flag_clear),
      .module_output_pin(module_output_pin),
      .module_event_flag(module_event_flag),
      .flag_irq(flag_irq),
      .wdog_expire(wdog_expire)
   );

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic stop_test();
      if (miscompares == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test

   task automatic check8(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("BAD time=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : check8

   task automatic check1(input logic g, input logic e);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("BAD time=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : check1

   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask : idle

   // Strobes are one cycle wide and separated by an idle cycle, except the two-cycle read strobe of read_pair
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge mclk);
      sfr_wr = 1'b0;
   endtask : sfr_write

   task automatic read_check(input logic [7:0] a, input logic [7:0] e);
      @(negedge mclk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge mclk);
      sfr_rd = 1'b0;
      rd_v = sfr_rdata;
      check8(rd_v, e);
   endtask : read_check

   // Low then high read back to back, the coherent way to fetch the counter
   task automatic read_pair(input logic [7:0] elo, input logic [7:0] ehi);
      @(negedge mclk);
      sfr_addr = `CAM_ADDR_CNT_LO;
      sfr_rd = 1'b1;
      @(negedge mclk);
      check8(sfr_rdata, elo);
      sfr_addr = `CAM_ADDR_CNT_HI;
      @(negedge mclk);
      sfr_rd = 1'b0;
      check8(sfr_rdata, ehi);
   endtask : read_pair

   task automatic set_cnt(input logic [7:0] hi, input logic [7:0] lo);
      sfr_write(`CAM_ADDR_CNT_HI, hi);
      sfr_write(`CAM_ADDR_CNT_LO, lo);
   endtask : set_cnt

   task automatic set_cc(input int n, input logic [15:0] v);
      sfr_write(cpl_a[n], v[7:0]);
      sfr_write(cph_a[n], v[15:8]);
   endtask : set_cc

   task automatic pulse_clear(input logic [5:0] m);
      @(negedge mclk);
      flag_clear = m;
      @(negedge mclk);
      flag_clear = 6'h00;
   endtask : pulse_clear

   // Polls a flag (which 0) or an output pin (which 1) for a bounded time
   task automatic wait_hi(input int which, input int idx);
      got = 1'b0;
      repeat (40) begin
         if (got !== 1'b1) begin
            @(negedge mclk);
            got = (which == 0) ? module_event_flag[idx] : module_output_pin[idx];
         end
      end
   endtask : wait_hi

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      for (int i = 0; i < 6; i++) begin
         read_check(mode_a[i], `CAM_MODE_RESET);
      end
      read_check(`CAM_ADDR_CNT_LO, `CAM_BYTE_RESET);
      read_check(8'h80, 8'h00);
   endtask : t_reset

   task automatic t_modes();
      for (int i = 0; i < 6; i++) begin
         sfr_write(mode_a[i], 8'ha5 ^ 8'(i));
         read_check(mode_a[i], 8'ha5 ^ 8'(i));
      end
      wdog_enable_bit = 1'b1;
      sfr_write(mode_a[5], 8'h00);
      read_check(mode_a[5], 8'ha0);
      check1(wdog_expire, 1'b1);
      wdog_enable_bit = 1'b0;
      for (int i = 0; i < 6; i++) begin
         sfr_write(mode_a[i], 8'h00);
      end
      check1(wdog_expire, 1'b0);
      read_check(mode_a[5], 8'h00);
      pulse_clear(6'h3f);
   endtask : t_modes

   task automatic t_counter();
      set_cnt(8'h12, 8'h5a);
      read_check(`CAM_ADDR_CNT_LO, 8'h5a);
      read_check(`CAM_ADDR_CNT_HI, 8'h12);
      sfr_write(`CAM_ADDR_CNT_HI, 8'h77);
      read_check(`CAM_ADDR_CNT_HI, 8'h12);
      read_check(`CAM_ADDR_CNT_LO, 8'h5a);
      read_check(`CAM_ADDR_CNT_HI, 8'h77);
      wdog_enable_bit = 1'b1;
      sfr_write(`CAM_ADDR_CNT_LO, 8'h33);
      read_check(`CAM_ADDR_CNT_LO, 8'h5a);
      wdog_enable_bit = 1'b0;
      sfr_write(`CAM_ADDR_CNT_LO, 8'h33);
      read_check(`CAM_ADDR_CNT_LO, 8'h33);
      read_pair(8'h33, 8'h77);
   endtask : t_counter

   task automatic t_cmp_clear();
      for (int i = 0; i < 6; i++) begin
         sfr_write(mode_a[i], 8'h40);
         read_check(mode_a[i], 8'h40);
         sfr_write(cpl_a[i], 8'h00);
         read_check(mode_a[i], 8'h00);
      end
   endtask : t_cmp_clear

   task automatic t_match();
      set_cnt(8'h00, 8'h00);
      set_cc(0, 16'h0003);
      sfr_write(mode_a[0], 8'h49);
      idle(2);
      check1(module_event_flag[0], 1'b0);
      count_tick = 1'b1;
      wait_hi(0, 0);
      count_tick = 1'b0;
      check1(got, 1'b1);
      check1(flag_irq, 1'b1);
      sfr_write(mode_a[0], 8'h48);
      idle(1);
      check1(flag_irq, 1'b0);
      pulse_clear(6'h01);
      check1(module_event_flag[0], 1'b0);
      sfr_write(mode_a[0], 8'h00);
   endtask : t_match

   task automatic t_toggle();
      set_cnt(8'h00, 8'h00);
      set_cc(1, 16'h0005);
      sfr_write(mode_a[1], 8'h44);
      idle(2);
      check1(module_output_pin[1], 1'b0);
      count_tick = 1'b1;
      wait_hi(1, 1);
      count_tick = 1'b0;
      check1(got, 1'b1);
   endtask : t_toggle

   // High byte of the counter never matches, so only a low-byte compare can toggle
   task automatic t_freq();
      set_cnt(8'h55, 8'h00);
      set_cc(3, 16'h0004);
      sfr_write(mode_a[3], 8'h46);
      count_tick = 1'b1;
      wait_hi(1, 3);
      count_tick = 1'b0;
      check1(got, 1'b1);
   endtask : t_freq

   task automatic t_pwm();
      set_cc(2, 16'h8000);
      sfr_write(mode_a[2], 8'h42);
      set_cnt(8'h90, 8'h10);
      idle(2);
      check1(module_output_pin[2], 1'b1);
      set_cnt(8'h90, 8'h90);
      idle(2);
      check1(module_output_pin[2], 1'b0);
      sfr_write(mode_a[2], 8'hc2);
      set_cnt(8'h00, 8'h10);
      idle(2);
      check1(module_output_pin[2], 1'b1);
      set_cnt(8'h90, 8'h10);
      idle(2);
      check1(module_output_pin[2], 1'b0);
   endtask : t_pwm

   task automatic t_capture();
      sfr_write(mode_a[4], 8'h20);
      set_cnt(8'h12, 8'h34);
      pulse_clear(6'h10);
      capture_pin[4] = 1'b1;
      wait_hi(0, 4);
      check1(got, 1'b1);
      read_check(cpl_a[4], 8'h34);
      read_check(cph_a[4], 8'h12);
      pulse_clear(6'h10);
      capture_pin[4] = 1'b0;
      idle(10);
      check1(module_event_flag[4], 1'b0);
      sfr_write(mode_a[4], 8'h10);
      capture_pin[4] = 1'b1;
      idle(10);
      check1(module_event_flag[4], 1'b0);
      capture_pin[4] = 1'b0;
      wait_hi(0, 4);
      check1(got, 1'b1);
   endtask : t_capture

   // ****************************************
   // Main sequence and hang guard
   // ****************************************
   initial begin
      repeat (16) @(negedge mclk);
      nrst = 1'b1;
      t_reset();
      t_modes();
      t_counter();
      t_cmp_clear();
      t_match();
      t_toggle();
      t_freq();
      t_pwm();
      t_capture();
      stop_test();
   end

   // The sequence needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         miscompares = miscompares + 1;
         stop_test();
      end
   end
endmodule : cam_mode_ctrl_tb
